// >>> rtl/mcc_defines.svh
/*
 * Offsets, field positions, reset values and timing figures of the monitor
 * control and configuration registers.
 * Assumes inclusion by bare name from files under rtl/ and tb/.
 */
`ifndef MCC_DEFINES_SVH
`define MCC_DEFINES_SVH

// Register offsets reached through the I2C command pointer
`define MCC_CTRL_OFS 8'h10
`define MCC_MISC_OFS 8'h11
`define MCC_TEST_OFS 8'h12

// Control register fields
`define MCC_CTRL_GAIN_HI 7
`define MCC_CTRL_GAIN_LO 6
`define MCC_CTRL_SLP_BIT 5
`define MCC_CTRL_RST_BIT 3
`define MCC_CTRL_TCLR_BIT 2
`define MCC_CTRL_FTAG_BIT 1
`define MCC_CTRL_FIRQ_BIT 0

// Miscellaneous configuration fields
`define MCC_MISC_TSOW_BIT 3
`define MCC_MISC_LOGOW_BIT 2
`define MCC_MISC_REQ_BIT 1
`define MCC_MISC_PEC_BIT 0

// Self-test configuration fields
`define MCC_TEST_SHDN_BIT 3
`define MCC_TEST_RSVD_BIT 2
`define MCC_TEST_POR_HI 1
`define MCC_TEST_POR_LO 0

// Reset values
`define MCC_CTRL_RST 8'h00
`define MCC_MISC_RST 8'h0c
`define MCC_TEST_RST 8'h00

// Clock period and configuration wait time before ready
`define MCC_CLK_PERIOD_NS 10
`define MCC_CFG_WAIT_US 2000

// Target address on the I2C port
`define MCC_DEV_ADDR 7'h30

`endif

// >>> rtl/mcc_pkg.sv
/*
 * Types shared by the monitor control and configuration register block.
 * Assumes nothing of its surroundings.
 */
package mcc_pkg;

    // Comparator gain override codes
    typedef enum logic [1:0] {
        MCC_GAIN_NONE = 2'h0,
        MCC_GAIN_1X = 2'h1,
        MCC_GAIN_2X = 2'h2,
        MCC_GAIN_4X = 2'h3
    } mcc_gain_t;

    // I2C target byte engine states
    typedef enum logic [4:0] {
        MCC_I2C_IDLE = 5'h01,
        MCC_I2C_RX = 5'h02,
        MCC_I2C_ACK = 5'h04,
        MCC_I2C_TX = 5'h08,
        MCC_I2C_MACK = 5'h10
    } mcc_i2c_state_t;

    // Self-test scheduling states
    typedef enum logic [2:0] {
        MCC_ST_BOOT = 3'h1,
        MCC_ST_WAIT = 3'h2,
        MCC_ST_READY = 3'h4
    } mcc_st_state_t;

endpackage

// >>> rtl/mcc_crc8.sv
/*
 * Running CRC-8 (polynomial x^8+x^2+x+1, start value zero) over bus bytes.
 * Assumes clear and feed come from logic on the same clock.
 */
`timescale 1ns/1ns
module mcc_crc8 (
    input wire logic clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic feed,
    input wire logic [7:0] data,
    output logic [7:0] crc
);
    logic [7:0] crc_d;

    // One byte of CRC-8, most significant bit first
    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        end
        return r;
    endfunction

    // Clear wins so a new transaction never inherits an old residue
    always_comb begin
        crc_d = crc;
        if (clear) begin
            crc_d = 8'h00;
        end else if (feed) begin
            crc_d = crc_byte(crc, data);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            crc <= 8'h00;
        end else begin
            crc <= crc_d;
        end
    end
endmodule

// >>> rtl/mcc_regs.sv
/*
 * Monitor control, miscellaneous configuration and self-test configuration
 * registers of a voltage supervisor, reached through an I2C target port.
 * Assumes scl/sda and activity_request come from pins outside the clock
 * domain, all other inputs from logic on clk, and that full_reset_cmd is
 * routed back into srst by the surrounding device.
 */
//
// Function
// RL1 - Control bits 7:6 force comparator gain: none, 1x, 2x or 4x.
// RL2 - Control bit 5 picks low or high power sleep.
// RL3 - Writing 1 to control bit 3 fires a full device reset; reads 0.
// RL4 - Writing 1 to control bit 2 clears the rail-tag counter; reads 0.
// RL5 - Control bit 1 forces the rail-tag pin low, else sequence logic owns it.
// RL6 - Control bit 0 forces the interrupt pin low, else faults drive it.
// RL7 - Config bit 3 lets new sequences overwrite unread timestamps.
// RL8 - Config bit 2 lets new sequences overwrite unread order logs.
// RL9 - Config bit 0 enables packet error checking; off after reset.
// RL10 - With checking on, bit 1 makes a missing check byte a fault.
// RL11 - Self-test bit 3 runs self test when activity falls; ready after wait.
// RL12 - Nonvolatile load always clears the shutdown self-test bit.
// RL13 - Self-test bits 1:0 choose power-on self test; ready after wait.
// RL14 - Check byte is CRC-8 over every transaction byte, addresses included.
`timescale 1ns/1ns
`include "mcc_defines.svh"
module mcc_regs #(
    parameter logic [6:0] DEV_ADDR = `MCC_DEV_ADDR,
    parameter int WAIT_CYCLES =
        (`MCC_CFG_WAIT_US * 1000 + `MCC_CLK_PERIOD_NS - 1) / `MCC_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic activity_request,
    input wire logic fault_irq,
    input wire logic seq_tag_drive_low,
    input wire logic timestamp_ready,
    input wire logic [3:0] order_log_ready,
    input wire logic nvm_load,
    input wire logic [7:0] nvm_selftest_cfg,
    output mcc_pkg::mcc_gain_t comparator_gain_select,
    output logic sleep_power_level,
    output logic full_reset_cmd,
    output logic tag_count_clear,
    output logic rail_tag_oe_n,
    output logic interrupt_out_n,
    output logic timestamp_write_allow,
    output logic [3:0] order_log_write_allow,
    output logic packet_check_fault,
    output logic selftest_start,
    output logic device_ready
);
    import mcc_pkg::*;

    logic [2:0] scl_q, sda_q, act_q;
    mcc_i2c_state_t st_d, st_q;
    logic [3:0] bit_d, bit_q;
    logic [7:0] sh_d, sh_q, ptr_d, ptr_q, wdat_d, wdat_q;
    logic [1:0] idx_d, idx_q, txc_d, txc_q;
    logic rw_d, rw_q, wseen_d, wseen_q, pseen_d, pseen_q, mack_d, mack_q, txn_d, txn_q;
    logic sda_oe_n_d;
    logic [7:0] ctrl_d, ctrl_q, misc_d, misc_q, test_d, test_q;
    logic rst_cmd_d, tag_clr_d, pec_fault_d, load_tx;
    logic crc_clr, crc_feed;
    logic [7:0] crc_byte, crc_val, tx_byte;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    mcc_st_state_t sts_d, sts_q;
    logic [31:0] wcnt_d, wcnt_q;
    logic st_go_d;

    // Register read view; command bits and the reserved test bit read zero
    function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [7:0] c,
                                            input logic [7:0] m, input logic [7:0] t);
        logic [7:0] r;
        r = 8'h00;
        if (p == `MCC_CTRL_OFS) begin
            r = c;
            r[`MCC_CTRL_RST_BIT] = 1'b0; // RL3
            r[`MCC_CTRL_TCLR_BIT] = 1'b0; // RL4
        end else if (p == `MCC_MISC_OFS) begin
            r = m;
        end else if (p == `MCC_TEST_OFS) begin
            r = t;
            r[`MCC_TEST_RSVD_BIT] = 1'b0;
        end
        return r;
    endfunction

    // Bus conditions seen on the synchronised pins; stage 0 feeds stage 1 only
    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];
    assign start_cond = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign stop_cond = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    mcc_crc8 u_crc (
        .clk(clk),
        .srst(srst),
        .clear(crc_clr),
        .feed(crc_feed),
        .data(crc_byte),
        .crc(crc_val)
    );

    // Byte engine, register writes and pin-facing next values
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        idx_d = idx_q;
        rw_d = rw_q;
        ptr_d = ptr_q;
        wdat_d = wdat_q;
        wseen_d = wseen_q;
        pseen_d = pseen_q;
        mack_d = mack_q;
        txn_d = txn_q;
        txc_d = txc_q;
        sda_oe_n_d = sda_oe_n;
        ctrl_d = ctrl_q;
        misc_d = misc_q;
        test_d = test_q;
        rst_cmd_d = 1'b0;
        tag_clr_d = 1'b0;
        pec_fault_d = 1'b0;
        crc_clr = 1'b0;
        crc_feed = 1'b0;
        crc_byte = sh_q;
        load_tx = 1'b0;
        tx_byte = 8'hff;
        if (start_cond) begin
            // A repeated start keeps the running check value
            st_d = MCC_I2C_RX;
            bit_d = 4'h0;
            idx_d = 2'h0;
            sda_oe_n_d = 1'b1;
            crc_clr = ~txn_q; // RL14
            txn_d = 1'b1;
            if (!txn_q) begin
                wseen_d = 1'b0;
                pseen_d = 1'b0;
            end
        end else if (stop_cond) begin
            st_d = MCC_I2C_IDLE;
            txn_d = 1'b0;
            sda_oe_n_d = 1'b1;
            if (wseen_q) begin
                // Writes land only at stop, once the check byte is judged
                if (!misc_q[`MCC_MISC_PEC_BIT] ||
                    (pseen_q ? (crc_val == 8'h00) : !misc_q[`MCC_MISC_REQ_BIT])) begin // RL10
                    if (ptr_q == `MCC_CTRL_OFS) begin
                        ctrl_d = wdat_q;
                        ctrl_d[`MCC_CTRL_RST_BIT] = 1'b0;
                        ctrl_d[`MCC_CTRL_TCLR_BIT] = 1'b0;
                        rst_cmd_d = wdat_q[`MCC_CTRL_RST_BIT]; // RL3
                        tag_clr_d = wdat_q[`MCC_CTRL_TCLR_BIT]; // RL4
                    end else if (ptr_q == `MCC_MISC_OFS) begin
                        misc_d = wdat_q; // RL9
                    end else if (ptr_q == `MCC_TEST_OFS) begin
                        test_d = wdat_q;
                        test_d[`MCC_TEST_RSVD_BIT] = 1'b0;
                    end
                end else begin
                    pec_fault_d = 1'b1; // RL10
                end
            end
        end else begin
            unique case (st_q)
                MCC_I2C_IDLE: begin
                end
                MCC_I2C_RX: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_q[1]};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        crc_feed = 1'b1; // RL14
                        bit_d = 4'h0;
                        idx_d = (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
                        st_d = MCC_I2C_ACK;
                        sda_oe_n_d = 1'b0;
                        unique case (idx_q)
                            2'h0: begin
                                rw_d = sh_q[0];
                                txc_d = 2'h0;
                                if (sh_q[7:1] != DEV_ADDR) begin
                                    st_d = MCC_I2C_IDLE;
                                    sda_oe_n_d = 1'b1;
                                end
                            end
                            2'h1: ptr_d = sh_q;
                            2'h2: begin
                                wdat_d = sh_q;
                                wseen_d = 1'b1;
                            end
                            2'h3: pseen_d = wseen_q;
                        endcase
                    end
                end
                MCC_I2C_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n_d = 1'b1;
                        st_d = MCC_I2C_RX;
                        load_tx = rw_q;
                    end
                end
                MCC_I2C_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            st_d = MCC_I2C_MACK;
                            sda_oe_n_d = 1'b1;
                        end else begin
                            sda_oe_n_d = sh_q[7];
                            sh_d = {sh_q[6:0], 1'b0};
                            bit_d = bit_q + 4'h1;
                        end
                    end
                end
                MCC_I2C_MACK: begin
                    if (scl_rise) begin
                        mack_d = ~sda_q[1];
                    end else if (scl_fall) begin
                        st_d = MCC_I2C_IDLE;
                        load_tx = mack_q;
                    end
                end
            endcase
        end
        // First data byte, then the check byte, then filler
        if (load_tx) begin
            if (txc_q == 2'h0) begin
                tx_byte = reg_read(ptr_q, ctrl_q, misc_q, test_q);
            end else if (txc_q == 2'h1 && misc_q[`MCC_MISC_PEC_BIT]) begin
                tx_byte = crc_val; // RL14
            end
            crc_feed = (txc_q == 2'h0);
            crc_byte = tx_byte;
            txc_d = (txc_q == 2'h3) ? txc_q : txc_q + 2'h1;
            st_d = MCC_I2C_TX;
            sda_oe_n_d = tx_byte[7];
            sh_d = {tx_byte[6:0], 1'b0};
            bit_d = 4'h1;
        end
        // A nonvolatile load cannot arm the shutdown self test
        if (nvm_load) begin
            test_d = nvm_selftest_cfg;
            test_d[`MCC_TEST_SHDN_BIT] = 1'b0; // RL12
            test_d[`MCC_TEST_RSVD_BIT] = 1'b0;
        end
    end

    // Self-test scheduling; ready is withheld until the wait time has passed
    always_comb begin
        sts_d = sts_q;
        wcnt_d = wcnt_q;
        st_go_d = 1'b0;
        unique case (sts_q)
            MCC_ST_BOOT: begin
                if (nvm_load) begin
                    st_go_d = (nvm_selftest_cfg[`MCC_TEST_POR_HI:`MCC_TEST_POR_LO] != 2'h0); // RL13
                    sts_d = MCC_ST_WAIT;
                    wcnt_d = 32'h0;
                end
            end
            MCC_ST_WAIT: begin
                wcnt_d = wcnt_q + 32'h1;
                if (wcnt_q >= 32'(WAIT_CYCLES - 1)) begin
                    sts_d = MCC_ST_READY; // RL11
                end
            end
            MCC_ST_READY: begin
                if (act_q[2] && !act_q[1] && test_q[`MCC_TEST_SHDN_BIT]) begin // RL11
                    st_go_d = 1'b1;
                    sts_d = MCC_ST_WAIT;
                    wcnt_d = 32'h0;
                end
            end
        endcase
    end

    // All state and every output register
    always_ff @(posedge clk) begin
        scl_q <= {scl_q[1:0], scl_in};
        sda_q <= {sda_q[1:0], sda_in};
        act_q <= {act_q[1:0], activity_request};
        if (srst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            act_q <= 3'h0;
            st_q <= MCC_I2C_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            idx_q <= 2'h0;
            txc_q <= 2'h0;
            rw_q <= 1'b0;
            ptr_q <= 8'h00;
            wdat_q <= 8'h00;
            wseen_q <= 1'b0;
            pseen_q <= 1'b0;
            mack_q <= 1'b0;
            txn_q <= 1'b0;
            ctrl_q <= `MCC_CTRL_RST;
            misc_q <= `MCC_MISC_RST;
            test_q <= `MCC_TEST_RST;
            sts_q <= MCC_ST_BOOT;
            wcnt_q <= 32'h0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            comparator_gain_select <= MCC_GAIN_NONE;
            sleep_power_level <= 1'b0;
            full_reset_cmd <= 1'b0;
            tag_count_clear <= 1'b0;
            rail_tag_oe_n <= 1'b1;
            interrupt_out_n <= 1'b1;
            timestamp_write_allow <= 1'b1;
            order_log_write_allow <= 4'hf;
            packet_check_fault <= 1'b0;
            selftest_start <= 1'b0;
            device_ready <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            txc_q <= txc_d;
            rw_q <= rw_d;
            ptr_q <= ptr_d;
            wdat_q <= wdat_d;
            wseen_q <= wseen_d;
            pseen_q <= pseen_d;
            mack_q <= mack_d;
            txn_q <= txn_d;
            ctrl_q <= ctrl_d;
            misc_q <= misc_d;
            test_q <= test_d;
            sts_q <= sts_d;
            wcnt_q <= wcnt_d;
            sda_out <= 1'b0;
            sda_oe_n <= sda_oe_n_d;
            comparator_gain_select <= mcc_gain_t'(ctrl_d[`MCC_CTRL_GAIN_HI:`MCC_CTRL_GAIN_LO]); // RL1
            sleep_power_level <= ctrl_d[`MCC_CTRL_SLP_BIT]; // RL2
            full_reset_cmd <= rst_cmd_d; // RL3
            tag_count_clear <= tag_clr_d; // RL4
            rail_tag_oe_n <= ~(ctrl_q[`MCC_CTRL_FTAG_BIT] | seq_tag_drive_low); // RL5
            interrupt_out_n <= ~(ctrl_q[`MCC_CTRL_FIRQ_BIT] | fault_irq); // RL6
            timestamp_write_allow <= misc_q[`MCC_MISC_TSOW_BIT] | ~timestamp_ready; // RL7
            order_log_write_allow <= {4{misc_q[`MCC_MISC_LOGOW_BIT]}} | ~order_log_ready; // RL8
            packet_check_fault <= pec_fault_d;
            selftest_start <= st_go_d; // RL13
            device_ready <= (sts_d == MCC_ST_READY);
        end
    end
endmodule

// >>> tb/mcc_regs_checker.sv
/*
 * Port-level concurrent checks of the monitor control register block.
 * Assumes it is bound onto mcc_regs and that everything runs on clk.
 */
`timescale 1ns/1ns
module mcc_regs_checker #(
    parameter int WAIT_CYCLES = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic fault_irq,
    input wire logic seq_tag_drive_low,
    input wire logic timestamp_ready,
    input wire logic [3:0] order_log_ready,
    input wire logic nvm_load,
    input wire logic [7:0] nvm_selftest_cfg,
    input wire logic full_reset_cmd,
    input wire logic tag_count_clear,
    input wire logic rail_tag_oe_n,
    input wire logic interrupt_out_n,
    input wire logic timestamp_write_allow,
    input wire logic [3:0] order_log_write_allow,
    input wire logic packet_check_fault,
    input wire logic selftest_start,
    input wire logic device_ready
);
    // Slack for the shutdown path, whose start pulse trails the wait count
    localparam int MIN_GAP = WAIT_CYCLES - 2;
    logic [31:0] since_q, since_d;
    logic live_q, live_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Cycles since the last load or self test start; saturates, never wraps
    always_comb begin
        since_d = since_q + {31'h0, ~&since_q};
        if (srst || nvm_load || selftest_start) begin
            since_d = 32'h0;
        end
        live_d = !srst;
    end
    always_ff @(posedge clk) begin
        since_q <= since_d;
        live_q <= live_d;
    end
    sequence s_load_run;
        nvm_load && nvm_selftest_cfg[1:0] != 2'h0;
    endsequence
    sequence s_load_skip;
        nvm_load && nvm_selftest_cfg[1:0] == 2'h0;
    endsequence
    sequence s_ready_low;
        !device_ready [*4];
    endsequence
    a_tag_follows_req: assert property (live_q && $past(seq_tag_drive_low) |-> !rail_tag_oe_n)
        else $error("rail tag pin not low on request");
    a_irq_follows_fault: assert property (live_q && $past(fault_irq) |-> !interrupt_out_n)
        else $error("interrupt pin not low with fault");
    a_ts_allow_free: assert property (live_q && !$past(timestamp_ready) |-> timestamp_write_allow)
        else $error("timestamp write blocked with nothing unread");
    a_log_allow_free: assert property (live_q |-> (~$past(order_log_ready) & ~order_log_write_allow) == 4'h0)
        else $error("order log write blocked with nothing unread");
    a_reset_one_cycle: assert property (full_reset_cmd |=> !full_reset_cmd)
        else $error("full reset pulse too long");
    a_clear_one_cycle: assert property (tag_count_clear |=> !tag_count_clear)
        else $error("tag clear pulse too long");
    a_fault_one_cycle: assert property (packet_check_fault |=> !packet_check_fault)
        else $error("check fault pulse too long");
    a_load_runs_test: assert property (s_load_run |=> selftest_start)
        else $error("power-on self test not started");
    a_load_skips_test: assert property (s_load_skip |=> !selftest_start)
        else $error("power-on self test started for skip code");
    a_shdn_holds_ready: assert property (selftest_start && !$past(nvm_load) |=> s_ready_low)
        else $error("ready during shutdown self test");
    a_ready_after_wait: assert property ($rose(device_ready) |-> since_q >= MIN_GAP)
        else $error("ready before the wait time");
endmodule
bind mcc_regs mcc_regs_checker #(.WAIT_CYCLES(WAIT_CYCLES)) u_chk (.*);

// >>> tb/mcc_i2c_host.sv
/*
 * Behavioural I2C host: start, stop, byte out and byte in at 125 ns a bit.
 * Assumes the bench forms the pulled-up SDA level and feeds it back.
 */
`timescale 1ns/1ns
module mcc_i2c_host (
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    // Idle bus: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Data moves mid-low and is read mid-high, well clear of both edges
    task automatic bit_io(input logic b, output logic s);
        #31 sda_low = ~b;
        #31 scl = 1'b1;
        #31 s = sda_line;
        #32 scl = 1'b0;
    endtask
    task automatic start();
        if (scl == 1'b0) begin
            #31 sda_low = 1'b0;
            #31 scl = 1'b1;
        end
        #31 sda_low = 1'b1;
        #32 scl = 1'b0;
    endtask
    task automatic stop();
        #31 sda_low = 1'b1;
        #31 scl = 1'b1;
        #31 sda_low = 1'b0;
        #32;
    endtask
    // Byte out, MSB first; ack is 1 when the target pulled SDA low
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~mack, s);
    endtask
endmodule

// >>> tb/tb_top.sv
/*
 * Self-checking bench of the monitor control register block.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/1ns
`include "mcc_defines.svh"
module tb_top;
    import mcc_pkg::*;
    localparam int WAIT = 20;
    localparam logic [7:0] AW = {`MCC_DEV_ADDR, 1'b0};
    logic clk, srst, scl, sda_low, sda_in, sda_out, sda_oe_n, activity_request, ack;
    logic fault_irq, seq_tag_drive_low, timestamp_ready, nvm_load, sleep_power_level;
    logic full_reset_cmd, tag_count_clear, rail_tag_oe_n, interrupt_out_n;
    logic timestamp_write_allow, packet_check_fault, selftest_start, device_ready;
    logic [3:0] order_log_ready, order_log_write_allow;
    logic [7:0] nvm_selftest_cfg, rd, v, g;
    logic [31:0] lf = 32'h9dff;
    mcc_gain_t comparator_gain_select;
    int fails = 0, comparisons = 0, n_rst = 0, n_clr = 0, n_flt = 0, n_st = 0, b0, b1;
    // Open-drain data line with its pull-up
    assign sda_in = ~(sda_low | ~sda_oe_n);
    assign g = {6'h0, comparator_gain_select};
    mcc_regs #(.WAIT_CYCLES(WAIT)) dut (.*, .scl_in(scl));
    mcc_i2c_host host (.scl(scl), .sda_low(sda_low), .sda_line(sda_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulses stand one cycle, so count them
    always @(posedge clk) begin
        n_rst += int'(full_reset_cmd === 1'b1);
        n_clr += int'(tag_count_clear === 1'b1);
        n_flt += int'(packet_check_fault === 1'b1);
        n_st += int'(selftest_start === 1'b1);
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] z(input logic x);
        return {7'h0, x};
    endfunction
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        return r;
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Mode 1 adds a good check byte, 2 a bad one
    task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d, input int mode);
        logic [7:0] c;
        c = crc(crc(crc(8'h00, AW), ofs), d);
        host.start();
        host.send(AW, ack);
        host.send(ofs, ack);
        host.send(d, ack);
        if (mode != 0) host.send(c ^ z(mode == 2), ack);
        host.stop();
        repeat (10) @(negedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] ofs);
        host.start();
        host.send(AW, ack);
        host.send(ofs, ack);
        host.start();
        host.send(AW | 8'h01, ack);
        host.recv(1'b0, rd);
        host.stop();
        repeat (10) @(negedge clk);
    endtask
    // Random status levels
    task automatic pins();
        lf = nxt(lf);
        fault_irq = lf[0];
        seq_tag_drive_low = lf[1];
        timestamp_ready = lf[2];
        order_log_ready = lf[6:3];
        repeat (4) @(negedge clk);
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        wrap_up();
    end
    initial begin
        {srst, activity_request, fault_irq, seq_tag_drive_low, timestamp_ready} = 5'h10;
        {order_log_ready, nvm_load, nvm_selftest_cfg} = 13'h0;
        repeat (6) @(negedge clk);
        srst = 1'b0;
        activity_request = 1'b1;
        repeat (4) @(negedge clk);
        rd_reg(8'h11);
        check("misc reset", rd & 8'h0f, 8'h0c);
        rd_reg(8'h13);
        check("unmapped", rd, 8'h00);
        // Gain codes, random other bits
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            v = {i[1:0], lf[5:0]};
            b0 = n_rst;
            b1 = n_clr;
            wr_reg(8'h10, v, 0);
            check("gain", g, {6'h0, v[7:6]});
            check("sleep", z(sleep_power_level), z(v[5]));
            check("reset pulse", 8'(n_rst - b0), z(v[3]));
            check("clear pulse", 8'(n_clr - b1), z(v[2]));
            pins();
            check("tag pin", z(rail_tag_oe_n), z(~(v[1] | seq_tag_drive_low)));
            check("irq pin", z(interrupt_out_n), z(~(v[0] | fault_irq)));
            rd_reg(8'h10);
            check("ctrl read", rd & 8'hef, v & 8'he3);
        end
        // Overwrite permissions against unread flags
        for (int j = 0; j < 4; j++) begin
            v = {4'h0, j[1:0], 2'b00};
            wr_reg(8'h11, v, 0);
            pins();
            check("ts allow", z(timestamp_write_allow), z(v[3] | ~timestamp_ready));
            v[7:4] = {4{v[2]}} | ~order_log_ready;
            check("log allow", {4'h0, order_log_write_allow}, {4'h0, v[7:4]});
        end
        // Check byte: good, corrupt, optional, required
        wr_reg(8'h11, 8'h01, 0);
        b0 = n_flt;
        wr_reg(8'h10, 8'h40, 1);
        check("good check", g, 8'h01);
        wr_reg(8'h10, 8'h80, 2);
        check("bad check", g, 8'h01);
        wr_reg(8'h10, 8'hc0, 0);
        check("optional", g, 8'h03);
        wr_reg(8'h11, 8'h03, 1);
        wr_reg(8'h10, 8'h00, 0);
        check("required", g, 8'h03);
        check("faults", 8'(n_flt - b0), 8'h02);
        wr_reg(8'h11, 8'h0c, 1);
        wr_reg(8'h10, 8'h00, 0);
        check("check off", g, 8'h00);
        // Power-on codes, each after a reset; bits 3:2 must not load
        for (int k = 0; k < 4; k++) begin
            srst = 1'b1;
            repeat (3) @(negedge clk);
            srst = 1'b0;
            b0 = n_st;
            nvm_selftest_cfg = 8'h0c | 8'(k);
            nvm_load = 1'b1;
            @(negedge clk);
            nvm_load = 1'b0;
            repeat (WAIT - 1) @(negedge clk);
            check("early ready", z(device_ready), 8'h00);
            repeat (2) @(negedge clk);
            check("ready", z(device_ready), 8'h01);
            check("por start", 8'(n_st - b0), z(k != 0));
            rd_reg(8'h12);
            check("test read", rd & 8'h0f, 8'(k));
        end
        // Shutdown self test runs only with its bit set
        for (int m = 1; m >= 0; m--) begin
            wr_reg(8'h12, {4'h0, m[0], 3'h0}, 0);
            b0 = n_st;
            activity_request = 1'b0;
            repeat (8) @(negedge clk);
            check("shdn start", 8'(n_st - b0), z(m[0]));
            check("shdn ready", z(device_ready), z(~m[0]));
            repeat (WAIT + 4) @(negedge clk);
            check("ready back", z(device_ready), 8'h01);
            activity_request = 1'b1;
            repeat (8) @(negedge clk);
        end
        wrap_up();
    end
endmodule
